// ---- logic/dtc_defs.vh ----
// Purpose: constants for the dual timer/counter block (register indices, fields, modes, reset values)
// Assumes: AXI4-Lite byte address = 4 * register index
// Notes: included by bare name; definitions only
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// ************************************************************
// register indices (byte address is index times four)
// ************************************************************
`define DTC_IDX_W          10
`define DTC_IDX_CTRL       10'h088
`define DTC_IDX_MODE       10'h089
`define DTC_IDX_TL0        10'h08A
`define DTC_IDX_TL1        10'h08B
`define DTC_IDX_TH0        10'h08C
`define DTC_IDX_TH1        10'h08D
`define DTC_IDX_CKSEL      10'h08E
`define DTC_IDX_PINSET     10'h0B5

// ************************************************************
// field positions
// ************************************************************
`define DTC_CTRL_TF1       7
`define DTC_CTRL_TR1       6
`define DTC_CTRL_TF0       5
`define DTC_CTRL_TR0       4
`define DTC_MODE_GATE1     7
`define DTC_MODE_CT1       6
`define DTC_MODE_M1_HI     5
`define DTC_MODE_M1_LO     4
`define DTC_MODE_GATE0     3
`define DTC_MODE_CT0       2
`define DTC_MODE_M0_HI     1
`define DTC_MODE_M0_LO     0
`define DTC_CKSEL_T1M      4
`define DTC_CKSEL_T0M      3
`define DTC_PIN_T1OE       3
`define DTC_PIN_T0OE       2

// ************************************************************
// modes, resets, responses
// ************************************************************
`define DTC_MODE_13        2'h0
`define DTC_MODE_16        2'h1
`define DTC_MODE_RELOAD    2'h2
`define DTC_MODE_SPLIT     2'h3
`define DTC_RST_BYTE       8'h00
`define DTC_LOW5_MSB       4
`define DTC_PRESCALE       12
`define DTC_RESP_OKAY      2'h0
`define DTC_RESP_SLVERR    2'h2

`endif

// ---- logic/dtc_timer.v ----
// Purpose: two 16-bit timer/counters with four modes, toggle pins and baud tick, AXI4-Lite registers
// Assumes: pins synchronous to aclk; one write and one read outstanding at a time
// Notes: external interrupt edge/level bits of the control register read as zero
`timescale 1ns/1ps
`include "dtc_defs.vh"

module dtc_timer #(
  parameter ADDR_W    = 12,
  parameter PRESCALE  = `DTC_PRESCALE
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              isr_entry_zero,
  input  wire              isr_entry_one,
  input  wire              ext_gate_pin_zero,
  input  wire              ext_gate_pin_one,
  input  wire              count_pin_zero_i,
  output reg               count_pin_zero_o,
  output reg               count_pin_zero_oe,
  input  wire              count_pin_one_i,
  output reg               count_pin_one_o,
  output reg               count_pin_one_oe,
  output reg               ovf_flag_zero,
  output reg               ovf_flag_one,
  output reg               baud_tick_one
);

  // ************************************************************
  // helpers
  // ************************************************************
  // one counting step for a given mode: {overflow, high, low}
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [13:0] s13;
    reg   [16:0] s16;
    reg   [8:0]  s8;
    begin
      s13 = {1'b0, hi, lo[`DTC_LOW5_MSB:0]} + 14'h0001;
      s16 = {1'b0, hi, lo} + 17'h00001;
      s8  = {1'b0, lo} + 9'h001;
      case (mode)
        `DTC_MODE_13: begin
          dtc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
        end
        `DTC_MODE_16: begin
          dtc_step = s16;
        end
        `DTC_MODE_RELOAD: begin
          dtc_step = s8[8] ? {1'b1, hi, hi} : {1'b0, hi, s8[7:0]};
        end
        default: begin
          dtc_step = {s8[8], hi, s8[7:0]}; // low byte alone, split mode
        end
      endcase
    end
  endfunction

  function [`DTC_IDX_W-1:0] dtc_index;
    input [ADDR_W-1:0] addr;
    begin
      dtc_index = addr[`DTC_IDX_W+1:2];
    end
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  reg         tf1_reg, tr1_reg, tf0_reg, tr0_reg;
  reg  [7:0]  mode_reg;
  reg  [7:0]  tl0_reg, th0_reg, tl1_reg, th1_reg;
  reg         clkm1_reg, clkm0_reg;
  reg         toe1_reg, toe0_reg;
  reg         pin0_prev_reg, pin1_prev_reg;
  reg  [3:0]  pre_cnt_reg;
  reg         pre_tick_reg;
  reg         aw_held_reg, w_held_reg;
  reg  [`DTC_IDX_W-1:0] aw_idx_reg;
  reg  [31:0] wdata_reg;
  reg         wlane_reg;

  // ************************************************************
  // divide-by-12 enable
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt_reg  <= 4'h0;
      pre_tick_reg <= 1'b0;
    end else if (pre_cnt_reg == PRESCALE[3:0] - 4'h1) begin
      pre_cnt_reg  <= 4'h0;
      pre_tick_reg <= 1'b1;
    end else begin
      pre_cnt_reg  <= pre_cnt_reg + 4'h1;
      pre_tick_reg <= 1'b0;
    end
  end

  // ************************************************************
  // count sources
  // ************************************************************
  wire [1:0] mode0   = {mode_reg[`DTC_MODE_M0_HI], mode_reg[`DTC_MODE_M0_LO]};
  wire [1:0] mode1   = {mode_reg[`DTC_MODE_M1_HI], mode_reg[`DTC_MODE_M1_LO]};
  wire       split0  = (mode0 == `DTC_MODE_SPLIT);
  wire       fall0   = pin0_prev_reg & ~count_pin_zero_i;
  wire       fall1   = pin1_prev_reg & ~count_pin_one_i;
  wire       clk0    = clkm0_reg | pre_tick_reg;
  wire       clk1    = clkm1_reg | pre_tick_reg;
  wire       tick0   = mode_reg[`DTC_MODE_CT0] ? fall0 : clk0;
  wire       tick1   = mode_reg[`DTC_MODE_CT1] ? fall1 : clk1;
  wire       gate_ok0 = ~mode_reg[`DTC_MODE_GATE0] | ext_gate_pin_zero;
  wire       gate_ok1 = ~mode_reg[`DTC_MODE_GATE1] | ext_gate_pin_one;
  // split: timer one ignores run one, stops in its own mode 3 or when its gate holds it off
  wire       run1    = split0 ? 1'b1 : tr1_reg;
  wire       step0   = tr0_reg & gate_ok0 & tick0;
  wire       step1   = run1 & gate_ok1 & tick1 & (mode1 != `DTC_MODE_SPLIT);
  wire       step_h0 = split0 & tr1_reg & clk0;
  wire [16:0] res0   = dtc_step(mode0, th0_reg, tl0_reg);
  wire [16:0] res1   = dtc_step(mode1, th1_reg, tl1_reg);
  wire [8:0]  sum_h0 = {1'b0, th0_reg} + 9'h001;
  wire       ovf0    = step0 & res0[16];
  wire       ovf1    = step1 & res1[16];
  wire       ovf_h0  = step_h0 & sum_h0[8];
  wire       set_tf1 = split0 ? ovf_h0 : ovf1;

  // ************************************************************
  // bus write decode
  // ************************************************************
  wire                  wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire                  wr_lane = wr_fire & wlane_reg;
  wire [7:0]            wbyte   = wdata_reg[7:0];
  reg                   wr_ctrl, wr_mode, wr_tl0, wr_tl1, wr_th0, wr_th1, wr_cksel, wr_pin, wr_hit;

  always @* begin
    wr_ctrl  = 1'b0;
    wr_mode  = 1'b0;
    wr_tl0   = 1'b0;
    wr_tl1   = 1'b0;
    wr_th0   = 1'b0;
    wr_th1   = 1'b0;
    wr_cksel = 1'b0;
    wr_pin   = 1'b0;
    wr_hit   = 1'b1;
    if (aw_idx_reg == `DTC_IDX_CTRL) begin
      wr_ctrl = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_MODE) begin
      wr_mode = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_TL0) begin
      wr_tl0 = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_TL1) begin
      wr_tl1 = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_TH0) begin
      wr_th0 = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_TH1) begin
      wr_th1 = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_CKSEL) begin
      wr_cksel = wr_lane;
    end else if (aw_idx_reg == `DTC_IDX_PINSET) begin
      wr_pin = wr_lane;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // ************************************************************
  // counters and flags
  // ************************************************************
  reg [7:0] tl0_next, th0_next, tl1_next, th1_next;
  reg       tf0_next, tf1_next;

  always @* begin
    tl0_next = tl0_reg;
    th0_next = th0_reg;
    tl1_next = tl1_reg;
    th1_next = th1_reg;
    if (step0) begin
      tl0_next = res0[7:0];
      if (!split0) begin
        th0_next = res0[15:8];
      end
    end
    if (step_h0) begin
      th0_next = sum_h0[7:0];
    end
    if (step1) begin
      tl1_next = res1[7:0];
      th1_next = res1[15:8];
    end
    // software write discards this cycle's increment of the written byte
    if (wr_tl0) begin
      tl0_next = wbyte;
    end
    if (wr_th0) begin
      th0_next = wbyte;
    end
    if (wr_tl1) begin
      tl1_next = wbyte;
    end
    if (wr_th1) begin
      th1_next = wbyte;
    end
    tf0_next = tf0_reg;
    tf1_next = tf1_reg;
    if (isr_entry_zero) begin
      tf0_next = 1'b0;
    end
    if (isr_entry_one) begin
      tf1_next = 1'b0;
    end
    if (wr_ctrl) begin
      tf0_next = wbyte[`DTC_CTRL_TF0];
      tf1_next = wbyte[`DTC_CTRL_TF1];
    end
    // set wins over any clear so no overflow is lost
    if (ovf0) begin
      tf0_next = 1'b1;
    end
    if (set_tf1) begin
      tf1_next = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      tl0_reg           <= `DTC_RST_BYTE;
      th0_reg           <= `DTC_RST_BYTE;
      tl1_reg           <= `DTC_RST_BYTE;
      th1_reg           <= `DTC_RST_BYTE;
      tf0_reg           <= 1'b0;
      tf1_reg           <= 1'b0;
      tr0_reg           <= 1'b0;
      tr1_reg           <= 1'b0;
      mode_reg          <= `DTC_RST_BYTE;
      clkm0_reg         <= 1'b0;
      clkm1_reg         <= 1'b0;
      toe0_reg          <= 1'b0;
      toe1_reg          <= 1'b0;
      pin0_prev_reg     <= 1'b0;
      pin1_prev_reg     <= 1'b0;
      ovf_flag_zero     <= 1'b0;
      ovf_flag_one      <= 1'b0;
      baud_tick_one     <= 1'b0;
      count_pin_zero_o  <= 1'b1;
      count_pin_one_o   <= 1'b1;
      count_pin_zero_oe <= 1'b0;
      count_pin_one_oe  <= 1'b0;
    end else begin
      tl0_reg       <= tl0_next;
      th0_reg       <= th0_next;
      tl1_reg       <= tl1_next;
      th1_reg       <= th1_next;
      tf0_reg       <= tf0_next;
      tf1_reg       <= tf1_next;
      ovf_flag_zero <= tf0_next;
      ovf_flag_one  <= tf1_next;
      pin0_prev_reg <= count_pin_zero_i;
      pin1_prev_reg <= count_pin_one_i;
      // only timer one feeds the serial port
      baud_tick_one <= ovf1;
      if (wr_ctrl) begin
        tr0_reg <= wbyte[`DTC_CTRL_TR0];
        tr1_reg <= wbyte[`DTC_CTRL_TR1];
      end
      if (wr_mode) begin
        mode_reg <= wbyte;
      end
      if (wr_cksel) begin
        clkm0_reg <= wbyte[`DTC_CKSEL_T0M];
        clkm1_reg <= wbyte[`DTC_CKSEL_T1M];
      end
      if (wr_pin) begin
        toe0_reg          <= wbyte[`DTC_PIN_T0OE];
        toe1_reg          <= wbyte[`DTC_PIN_T1OE];
        count_pin_zero_oe <= wbyte[`DTC_PIN_T0OE];
        count_pin_one_oe  <= wbyte[`DTC_PIN_T1OE];
      end
      // pin idles at 1 while disabled, so the first overflow drives it low
      if (!(wr_pin ? wbyte[`DTC_PIN_T0OE] : toe0_reg)) begin
        count_pin_zero_o <= 1'b1;
      end else if (ovf0) begin
        count_pin_zero_o <= ~count_pin_zero_o;
      end
      if (!(wr_pin ? wbyte[`DTC_PIN_T1OE] : toe1_reg)) begin
        count_pin_one_o <= 1'b1;
      end else if (ovf1) begin
        count_pin_one_o <= ~count_pin_one_o;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite write channel
  // ************************************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_idx_reg    <= {`DTC_IDX_W{1'b0}};
      wdata_reg     <= 32'h00000000;
      wlane_reg     <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DTC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg   <= 1'b1;
        aw_idx_reg    <= dtc_index(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end else if (!aw_held_reg && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg   <= 1'b1;
        wdata_reg    <= s_axi_wdata;
        wlane_reg    <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end else if (!w_held_reg && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ************************************************************
  // AXI4-Lite read channel
  // ************************************************************
  wire [`DTC_IDX_W-1:0] ar_idx = dtc_index(s_axi_araddr);
  reg  [7:0]            rd_byte;
  reg                   rd_hit;

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (ar_idx == `DTC_IDX_CTRL) begin
      rd_byte = {tf1_reg, tr1_reg, tf0_reg, tr0_reg, 4'h0};
    end else if (ar_idx == `DTC_IDX_MODE) begin
      rd_byte = mode_reg;
    end else if (ar_idx == `DTC_IDX_TL0) begin
      rd_byte = tl0_reg;
    end else if (ar_idx == `DTC_IDX_TL1) begin
      rd_byte = tl1_reg;
    end else if (ar_idx == `DTC_IDX_TH0) begin
      rd_byte = th0_reg;
    end else if (ar_idx == `DTC_IDX_TH1) begin
      rd_byte = th1_reg;
    end else if (ar_idx == `DTC_IDX_CKSEL) begin
      rd_byte = {3'h0, clkm1_reg, clkm0_reg, 3'h0};
    end else if (ar_idx == `DTC_IDX_PINSET) begin
      rd_byte = {4'h0, toe1_reg, toe0_reg, 2'h0};
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `DTC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_byte};
      s_axi_rresp   <= rd_hit ? `DTC_RESP_OKAY : `DTC_RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ---- verification/dtc_timer_props.sv ----
// Purpose: port-level checker for the dual timer/counter block
// Assumes: single aclk domain, synchronous active-low reset
// Notes: attached to every dtc_timer instance by bind
`timescale 1ns/1ps
module dtc_timer_props #(
  parameter ADDR_W = 12
) (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        isr_entry_zero,
  input wire        isr_entry_one,
  input wire        count_pin_zero_o,
  input wire        count_pin_zero_oe,
  input wire        count_pin_one_o,
  input wire        count_pin_one_oe,
  input wire        ovf_flag_zero,
  input wire        ovf_flag_one,
  input wire        baud_tick_one
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ************************************************************
  // register bus
  // ************************************************************
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped or changed before bready");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped or changed before rready");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while read data pending");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");

  // ************************************************************
  // pins and flags
  // ************************************************************
  a_idle_pin_zero: assert property (!count_pin_zero_oe |-> count_pin_zero_o)
    else $error("pin zero output not high while disabled");
  a_idle_pin_one: assert property (!count_pin_one_oe |-> count_pin_one_o)
    else $error("pin one output not high while disabled");
  a_toggle_on_tick: assert property (baud_tick_one && count_pin_one_oe && $past(count_pin_one_oe)
    |-> count_pin_one_o != $past(count_pin_one_o))
    else $error("pin one did not toggle on overflow");
  // flags only fall by service entry or a register write
  a_flag_zero_clear: assert property ($fell(ovf_flag_zero) |-> $past(isr_entry_zero) || $rose(s_axi_bvalid))
    else $error("flag zero cleared without cause");
  a_flag_one_clear: assert property ($fell(ovf_flag_one) |-> $past(isr_entry_one) || $rose(s_axi_bvalid))
    else $error("flag one cleared without cause");
endmodule

bind dtc_timer dtc_timer_props #(.ADDR_W(ADDR_W)) u_dtc_timer_props (.*);

// ---- verification/dtc_pin_model.sv ----
// Purpose: external count pin as seen from outside the block
// Assumes: the source is a push-pull driver that yields while the block drives
// Notes: level driven by the bench stands in for the outside signal
`timescale 1ns/1ps
module dtc_pin_model (
  input  wire ext_lvl,
  input  wire pin_o,
  input  wire pin_oe,
  output wire pin
);
  // the block's toggle output wins while its enable is set; outside driver used whenever the enable is off
  assign pin = pin_oe ? pin_o : ext_lvl;
endmodule

// ---- verification/dtc_timer_tb_top.sv ----
// Purpose: self-checking bench for the dual timer/counter block
// Assumes: gate pins drive counting windows of exact length
// Notes: counts checked against a bench model of each mode
`timescale 1ns/1ps
`include "dtc_defs.vh"
module dtc_timer_tb_top;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, isr0, isr1, g0, g1, lv0, lv1;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata;
  wire        awready, wready, bvalid, arready, rvalid, po0, oe0, po1, oe1, f0, f1, tick, pin0, pin1;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     err_total, samples_checked, k;
  reg  [17:0] ex;
  reg  [7:0]  r;
  reg         tpar;

  dtc_timer u_dtc_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .isr_entry_zero(isr0),
    .isr_entry_one(isr1), .ext_gate_pin_zero(g0), .ext_gate_pin_one(g1), .count_pin_zero_i(pin0),
    .count_pin_zero_o(po0), .count_pin_zero_oe(oe0), .count_pin_one_i(pin1), .count_pin_one_o(po1),
    .count_pin_one_oe(oe1), .ovf_flag_zero(f0), .ovf_flag_one(f1), .baud_tick_one(tick));
  dtc_pin_model u_dtc_pin_model_zero (.ext_lvl(lv0), .pin_o(po0), .pin_oe(oe0), .pin(pin0));
  dtc_pin_model u_dtc_pin_model_one (.ext_lvl(lv1), .pin_o(po1), .pin_oe(oe1), .pin(pin1));

  // parity of baud ticks, held against the model's overflow parity
  always @(posedge aclk) begin
    if (!aresetn) tpar <= 1'b0;
    else if (tick === 1'b1) tpar <= ~tpar;
  end

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask

  task chk(input [8*16-1:0] nm, input [31:0] e, input [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task wr(input [9:0] idx, input [7:0] d, input [1:0] er);
    integer i;
    begin
      @(posedge aclk);
      awaddr <= {idx, 2'b00}; wdata <= {24'h000000, d};
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      for (i = 0; i < 200 && !(bvalid && bready); i = i + 1) begin
        @(posedge aclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
      end
      if (i == 200) begin chk("wr_timeout", 0, 1); give_verdict; end
      chk("bresp", er, bresp);
      bready <= 1'b0;
    end
  endtask

  task rd(input [9:0] idx, input [7:0] e, input [7:0] msk, input [1:0] er);
    integer i;
    begin
      @(posedge aclk);
      araddr <= {idx, 2'b00}; arvalid <= 1'b1; rready <= 1'b1;
      for (i = 0; i < 200 && !(rvalid && rready); i = i + 1) begin
        @(posedge aclk);
        if (arvalid && arready) arvalid <= 1'b0;
      end
      if (i == 200) begin chk("rd_timeout", 0, 1); give_verdict; end
      chk("rdata", e & msk, rdata[7:0] & msk);
      chk("rresp", er, rresp);
      rready <= 1'b0;
    end
  endtask

  // bench model of n count steps: {toggle parity, overflow, high, low}
  function [17:0] model(input [1:0] m, input t, input [7:0] th, input [7:0] tl, input integer n);
    integer j; reg [15:0] v; reg ov, par;
    begin
      v = {th, tl}; ov = 1'b0; par = 1'b0;
      for (j = 0; j < n; j = j + 1) begin
        case (m)
          2'h0: begin {v[15:8], v[4:0]} = {v[15:8], v[4:0]} + 13'h0001;
            if ({v[15:8], v[4:0]} == 13'h0000) begin ov = 1'b1; par = ~par; end end
          2'h1: begin v = v + 16'h0001; if (v == 16'h0000) begin ov = 1'b1; par = ~par; end end
          2'h2: if (v[7:0] == 8'hFF) begin v[7:0] = v[15:8]; ov = 1'b1; par = ~par; end
                else v[7:0] = v[7:0] + 8'h01;
          default: if (!t) begin v[7:0] = v[7:0] + 8'h01;
            if (v[7:0] == 8'h00) begin ov = 1'b1; par = ~par; end end
        endcase
      end
      model = {par, ov, v};
    end
  endfunction

  // one counting window of n steps, then flags, pin and count bytes
  task run_case(input t, input [1:0] m, input [7:0] th, input [7:0] tl, input integer n, input cnt, input dv);
    reg tg, tp;
    begin
      tg = !cnt && m != 2'h3; // toggle only in timer function
      tp = tpar;
      ex = model(m, t, th, tl, n);
      wr(`DTC_IDX_MODE, t ? {1'b1, cnt, m, 4'h8} : {4'h8, 1'b1, cnt, m}, `DTC_RESP_OKAY);
      wr(`DTC_IDX_CKSEL, dv ? 8'h00 : (t ? 8'h10 : 8'h08), `DTC_RESP_OKAY);
      wr(`DTC_IDX_PINSET, tg ? (t ? 8'h08 : 8'h04) : 8'h00, `DTC_RESP_OKAY);
      wr(t ? `DTC_IDX_TH1 : `DTC_IDX_TH0, th, `DTC_RESP_OKAY);
      wr(t ? `DTC_IDX_TL1 : `DTC_IDX_TL0, tl, `DTC_RESP_OKAY);
      wr(`DTC_IDX_CTRL, t ? 8'h40 : 8'h10, `DTC_RESP_OKAY);
      repeat (30) @(posedge aclk);
      chk("no_gate_cnt", 0, t ? f1 : f0);
      if (t) g1 <= 1'b1; else g0 <= 1'b1;
      if (cnt) begin
        for (k = 0; k < n; k = k + 1) begin
          if (t) lv1 <= 1'b0; else lv0 <= 1'b0;
          repeat (2) @(posedge aclk);
          if (t) lv1 <= 1'b1; else lv0 <= 1'b1;
          repeat (2) @(posedge aclk);
        end
      end else repeat (dv ? n * `DTC_PRESCALE : n) @(posedge aclk);
      if (t) g1 <= 1'b0; else g0 <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("flag", ex[16], t ? f1 : f0);
      chk("baud_par", t ? ex[17] : 1'b0, tpar ^ tp);
      if (tg) chk("toggle_out", !ex[17], t ? po1 : po0);
      if (tg) chk("toggle_oe", 1, t ? oe1 : oe0);
      if (t) isr1 <= 1'b1; else isr0 <= 1'b1;
      @(posedge aclk);
      if (t) isr1 <= 1'b0; else isr0 <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("isr_clear", 0, t ? f1 : f0);
      rd(t ? `DTC_IDX_TH1 : `DTC_IDX_TH0, ex[15:8], 8'hFF, `DTC_RESP_OKAY);
      rd(t ? `DTC_IDX_TL1 : `DTC_IDX_TL0, ex[7:0], m == 2'h0 ? 8'h1F : 8'hFF, `DTC_RESP_OKAY);
      wr(`DTC_IDX_CTRL, 8'h00, `DTC_RESP_OKAY);
      wr(`DTC_IDX_PINSET, 8'h00, `DTC_RESP_OKAY);
      $display("test timer %0d mode %0d done", t, m);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    err_total = 0; samples_checked = 0;
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    isr0 = 1'b0; isr1 = 1'b0; g0 = 1'b0; g1 = 1'b0; lv0 = 1'b1; lv1 = 1'b1;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h00000000;
    r = $urandom(32'hD2F5);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(`DTC_IDX_TL0, `DTC_RST_BYTE, 8'hFF, `DTC_RESP_OKAY);
    rd(`DTC_IDX_TL1, `DTC_RST_BYTE, 8'hFF, `DTC_RESP_OKAY);
    rd(`DTC_IDX_TH0, `DTC_RST_BYTE, 8'hFF, `DTC_RESP_OKAY);
    rd(`DTC_IDX_CKSEL, `DTC_RST_BYTE, 8'hFF, `DTC_RESP_OKAY);
    rd(`DTC_IDX_PINSET, `DTC_RST_BYTE, 8'hFF, `DTC_RESP_OKAY);
    rd(10'h0FF, 8'h00, 8'hFF, `DTC_RESP_SLVERR);
    wr(10'h0FF, 8'h5A, `DTC_RESP_SLVERR);
    for (k = 0; k < 8; k = k + 1) begin
      r = $urandom;
      wr(`DTC_IDX_TL0 + k % 4, r, `DTC_RESP_OKAY);
      rd(`DTC_IDX_TL0 + k % 4, r, 8'hFF, `DTC_RESP_OKAY);
    end
    $display("test register access done");
    wr(`DTC_IDX_CTRL, 8'hA0, `DTC_RESP_OKAY);
    chk("sw_flag_zero", 1, f0);
    chk("sw_flag_one", 1, f1);
    rd(`DTC_IDX_CTRL, 8'hA0, 8'hF0, `DTC_RESP_OKAY);
    wr(`DTC_IDX_CTRL, 8'h00, `DTC_RESP_OKAY);
    r = $urandom;
    run_case(1'b0, 2'h0, 8'hFF, 8'hFE, 2, 1'b0, 1'b0);
    run_case(1'b0, 2'h1, 8'hFF, 8'hFE, 3, 1'b0, 1'b0);
    run_case(1'b0, 2'h2, r, 8'hFE, 3, 1'b0, 1'b0);
    run_case(1'b0, 2'h3, 8'h00, 8'hFE, 2, 1'b0, 1'b0);
    run_case(1'b0, 2'h1, 8'h00, 8'h10, 3, 1'b1, 1'b0);
    run_case(1'b1, 2'h0, 8'h12, 8'h34, 5, 1'b0, 1'b0);
    run_case(1'b1, 2'h1, 8'hFF, 8'hFF, 2, 1'b0, 1'b1);
    run_case(1'b1, 2'h2, 8'h80, 8'hFF, 1, 1'b1, 1'b0);
    run_case(1'b1, 2'h3, 8'hFF, 8'hFF, 4, 1'b0, 1'b0);
    // split: timer zero high byte runs on run bit one and sets flag one
    wr(`DTC_IDX_MODE, 8'h33, `DTC_RESP_OKAY);
    wr(`DTC_IDX_CKSEL, 8'h08, `DTC_RESP_OKAY);
    wr(`DTC_IDX_TH0, 8'hFF, `DTC_RESP_OKAY);
    wr(`DTC_IDX_CTRL, 8'h40, `DTC_RESP_OKAY);
    for (k = 0; k < 40 && f1 !== 1'b1; k = k + 1) @(posedge aclk);
    chk("split_flag_one", 1, f1);
    chk("split_flag_zero", 0, f0);
    wr(`DTC_IDX_CTRL, 8'h00, `DTC_RESP_OKAY);
    // split: timer one runs without its run bit, never sets flag one, halts in mode 3
    wr(`DTC_IDX_TH1, 8'hFF, `DTC_RESP_OKAY);
    wr(`DTC_IDX_MODE, 8'h23, `DTC_RESP_OKAY);
    wr(`DTC_IDX_CKSEL, 8'h18, `DTC_RESP_OKAY);
    repeat (4) @(posedge aclk);
    chk("split_t1_runs", 1, tick);
    chk("split_t1_flag", 0, f1);
    wr(`DTC_IDX_MODE, 8'h33, `DTC_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("split_t1_halt", 0, tick);
    $display("test split mode done");
    give_verdict;
  end
endmodule
